// ===== src/flash_dev_end.sv
// serial flash device end: pin sampling, pause, hardware reset,
// header decode to sector/block numbers and byte streaming
// assumes the master keeps sck near 160 ns so the 50 MHz clock sees every edge
// Function
// - pause pin is data line 3 when quad disabled
// - pause low while selected: freeze, output released
// - pause released: sequence continues where it stopped
// - hardware reset works whatever quad enable says
// - reset low: held in reset, outputs released
// - master avoids reset during internal writes
// - floating reset pin reads inactive via pull-up
// - clock modes 0 and 3 both accepted
// - idle clock low in mode 0, high mode 3
// - sample on rising edge, drive from falling edge
// - four-wire mode uses all four pins as data
// - uniform 4 KiB sectors, 32/64 KiB blocks
// - sector n spans n*4096 to n*4096+4095
// - chip select high: ignore input, outputs released
`timescale 1ns/10ps
module flash_dev_end
	import flash_pin_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// link pins
	flash_link_if.dev link,
	// configuration
	input wire logic i_quad_enable_bit,
	input wire logic i_four_wire_command_mode,
	// bytes to send in the data phase
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	// bytes received
	output logic [7:0] o_rx_data,
	output logic o_rx_first,
	output logic o_rx_valid,
	input wire logic i_rx_ready,
	output logic o_rx_overrun,
	// decoded header address
	output logic [SECTOR_W-1:0] o_sector,
	output logic [BLK32_W-1:0] o_blk32,
	output logic [BLK64_W-1:0] o_blk64,
	output logic [ADDR_W-1:0] o_sector_base,
	output logic o_addr_valid,
	// status
	output logic o_selected,
	output logic o_paused,
	output logic o_in_reset
);
	// two-stage synchronisers for {rst_n, cs_n, sck, io[3:0]}
	logic [6:0] pin_s1_r;
	logic [6:0] pin_s2_r;
	logic sck_prev_r;
	logic [3:0] bit_cnt_r;
	logic [2:0] byte_cnt_r;
	logic [7:0] rx_sr_r;
	logic [15:0] hdr_sr_r;
	logic dev_sends_r;
	logic [7:0] tx_sr_r;
	logic [3:0] out_r;
	logic [3:0] oe_r;
	logic [7:0] hold_r;
	logic hold_full_r;
	logic [8:0] head_r;
	logic [8:0] tail_r;
	logic head_v_r;
	logic tail_v_r;

	wire [3:0] io_s = pin_s2_r[3:0];
	wire sck_s = pin_s2_r[4];
	wire cs_n_s = pin_s2_r[5];
	wire rst_n_s = pin_s2_r[6];
	wire hw_reset = ~rst_n_s;
	wire pause_act = ~i_quad_enable_bit & ~io_s[IO_PAUSE] & ~cs_n_s;
	wire active = ~cs_n_s & ~hw_reset;
	wire run = active & ~pause_act;
	// both modes look alike once edges are found; a mode 3 lead-in fall does nothing
	wire rise = run & sck_s & ~sck_prev_r;
	wire fall = run & ~sck_s & sck_prev_r;
	wire [3:0] step = i_four_wire_command_mode ? STEP_QUAD : STEP_SINGLE;
	wire [3:0] bit_sum = bit_cnt_r + step;
	wire byte_done = rise & bit_sum[3];
	wire [7:0] rx_in = i_four_wire_command_mode ? {rx_sr_r[3:0], io_s} : {rx_sr_r[6:0], io_s[0]};
	wire data_phase = (byte_cnt_r == HDR_BYTES);
	wire first_byte = (byte_cnt_r == 3'h0);
	wire last_hdr = (byte_cnt_r == HDR_BYTES - 3'h1);
	wire sends_now = first_byte ? rx_in[DIR_BIT] : dev_sends_r;
	wire tx_load = byte_done & (last_hdr | data_phase) & sends_now;
	wire [7:0] tx_next = hold_full_r ? hold_r : IDLE_TX_BYTE;
	wire hold_take = i_tx_valid & o_tx_ready;
	wire hold_full_nxt = hold_take | (hold_full_r & ~tx_load);
	wire drive_now = fall & data_phase & dev_sends_r;
	wire [ADDR_W-1:0] addr_full = {hdr_sr_r, rx_in};
	// received bytes go to the user; bytes clocked in while we talk are discarded
	wire push = byte_done & ~(data_phase & dev_sends_r);
	wire pop = head_v_r & i_rx_ready;
	wire head_free = ~head_v_r | pop;
	wire [8:0] push_word = {first_byte, rx_in};

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			pin_s1_r <= 7'h7F;
			pin_s2_r <= 7'h7F;
			sck_prev_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= {link.rst_n, link.cs_n, link.sck, link.io};
			pin_s2_r <= pin_s1_r;
			sck_prev_r <= sck_s;
		end
	end

	// frame state survives a pause and is cleared only by deselect or reset
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			bit_cnt_r <= 4'h0;
			byte_cnt_r <= 3'h0;
			rx_sr_r <= 8'h00;
			hdr_sr_r <= 16'h0000;
			dev_sends_r <= 1'b0;
		end
		else if (~active)
		begin
			bit_cnt_r <= 4'h0;
			byte_cnt_r <= 3'h0;
			dev_sends_r <= 1'b0;
		end
		else if (rise)
		begin
			bit_cnt_r <= byte_done ? 4'h0 : bit_sum;
			rx_sr_r <= rx_in;
			if (byte_done & ~data_phase)
			begin
				byte_cnt_r <= byte_cnt_r + 3'h1;
				hdr_sr_r <= {hdr_sr_r[7:0], rx_in};
			end
			if (byte_done & first_byte)
				dev_sends_r <= rx_in[DIR_BIT];
		end
	end

	// output pins: driven only in a sending data phase, released at once otherwise
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			tx_sr_r <= IDLE_TX_BYTE;
			out_r <= 4'h0;
			oe_r <= 4'h0;
		end
		else
		begin
			if (tx_load)
				tx_sr_r <= tx_next;
			else if (drive_now)
				tx_sr_r <= i_four_wire_command_mode ? {tx_sr_r[3:0], 4'hF} : {tx_sr_r[6:0], 1'b1};
			if (~run | ~data_phase | ~dev_sends_r)
				oe_r <= 4'h0;
			else if (drive_now & i_four_wire_command_mode)
			begin
				out_r <= tx_sr_r[7:4];
				oe_r <= 4'hF;
			end
			else if (drive_now)
			begin
				out_r <= {2'b00, tx_sr_r[7], 1'b0};
				oe_r <= 4'h2;
			end
		end
	end

	assign link.d_io_o = out_r;
	assign link.d_io_oe = oe_r;

	// one-byte holding stage for send data
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			hold_r <= 8'h00;
			hold_full_r <= 1'b0;
			o_tx_ready <= 1'b0;
		end
		else
		begin
			if (hold_take)
				hold_r <= i_tx_data;
			hold_full_r <= hold_full_nxt;
			o_tx_ready <= ~hold_full_nxt;
		end
	end

	// two-entry receive buffer; the head is the output register
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			head_r <= 9'h000;
			tail_r <= 9'h000;
			head_v_r <= 1'b0;
			tail_v_r <= 1'b0;
			o_rx_overrun <= 1'b0;
		end
		else
		begin
			if (head_free)
			begin
				head_v_r <= tail_v_r | push;
				if (tail_v_r)
					head_r <= tail_r;
				else if (push)
					head_r <= push_word;
				tail_v_r <= tail_v_r & push;
				if (push)
					tail_r <= push_word;
			end
			else if (push & ~tail_v_r)
			begin
				tail_v_r <= 1'b1;
				tail_r <= push_word;
			end
			// a byte arriving with both entries full is dropped and flagged
			o_rx_overrun <= o_rx_overrun | (push & ~head_free & tail_v_r);
		end
	end

	assign o_rx_data = head_r[7:0];
	assign o_rx_first = head_r[8];
	assign o_rx_valid = head_v_r;

	// address decode once the third address byte is in
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_sector <= '0;
			o_blk32 <= '0;
			o_blk64 <= '0;
			o_sector_base <= '0;
			o_addr_valid <= 1'b0;
			o_selected <= 1'b0;
			o_paused <= 1'b0;
			o_in_reset <= 1'b0;
		end
		else
		begin
			o_addr_valid <= byte_done & last_hdr;
			if (byte_done & last_hdr)
			begin
				o_sector <= addr_full[SECTOR_MSB:SECTOR_LSB];
				o_blk32 <= addr_full[SECTOR_MSB:BLK32_LSB];
				o_blk64 <= addr_full[SECTOR_MSB:BLK64_LSB];
				o_sector_base <= {1'b0, addr_full[SECTOR_MSB:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
			end
			o_selected <= active;
			o_paused <= active & pause_act;
			o_in_reset <= hw_reset;
		end
	end

	if (SECTOR_BYTES != (1 << SECTOR_LSB) || LAST_SECTOR != (1 << SECTOR_W) - 1)
	begin : g_map_check
		$error("sector map constants disagree");
	end
endmodule : flash_dev_end

// ===== common/flash_pin_pkg.sv
// shared constants for the serial flash pin-level link
// assumes both ends run from one 50 MHz reference clock
package flash_pin_pkg;
	localparam int REF_PERIOD_NS = 20;
	localparam int SCK_PERIOD_NS = 160;
	localparam int SCK_HALF_CYC = SCK_PERIOD_NS / (2 * REF_PERIOD_NS);
	localparam int ADDR_W = 24;
	localparam int SECTOR_BYTES = 4096;
	localparam int LAST_SECTOR = 2047;
	localparam int SECTOR_LSB = 12;
	localparam int SECTOR_MSB = 22;
	localparam int BLK32_LSB = 15;
	localparam int BLK64_LSB = 16;
	localparam int SECTOR_W = SECTOR_MSB - SECTOR_LSB + 1;
	localparam int BLK32_W = SECTOR_MSB - BLK32_LSB + 1;
	localparam int BLK64_W = SECTOR_MSB - BLK64_LSB + 1;
	localparam logic [2:0] HDR_BYTES = 3'h4;
	localparam logic [3:0] STEP_SINGLE = 4'h1;
	localparam logic [3:0] STEP_QUAD = 4'h4;
	localparam int DIR_BIT = 7;
	localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
	localparam int IO_SO = 1;
	localparam int IO_WP = 2;
	localparam int IO_PAUSE = 3;
	typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_HOLD, H_TRAIL} host_state_t;
endpackage : flash_pin_pkg

// ===== common/flash_link_if.sv
// pin bundle between the flash device end and its master
// pull-ups on reset and data pins are modelled here, not in the ends
`timescale 1ns/10ps
interface flash_link_if;
	logic sck;
	logic cs_n;
	logic h_rst_n_o;
	logic h_rst_n_oe;
	logic [3:0] h_io_o;
	logic [3:0] h_io_oe;
	logic [3:0] d_io_o;
	logic [3:0] d_io_oe;
	wire rst_n;
	wire [3:0] io;

	// an undriven reset pin floats high through the pull-up
	assign rst_n = h_rst_n_oe ? h_rst_n_o : 1'b1;
	genvar g;
	for (g = 0; g < 4; g++)
	begin : g_io
		assign io[g] = h_io_oe[g] ? h_io_o[g] : (d_io_oe[g] ? d_io_o[g] : 1'b1);
	end

	modport dev (input sck, input cs_n, input rst_n, input io,
		output d_io_o, output d_io_oe);
	modport host (output sck, output cs_n, output h_rst_n_o, output h_rst_n_oe,
		output h_io_o, output h_io_oe, input io);
endinterface : flash_link_if

// ===== src/flash_host_end.sv
// master end of the serial flash link: makes sck by dividing its own
// clock, sends opcode and 24-bit address, then moves data bytes
// assumes the user keeps its request fields stable while o_busy is high
`timescale 1ns/10ps
module flash_host_end
	import flash_pin_pkg::*;
#(
	parameter int LEN_W = 8
)
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// link pins
	flash_link_if.host link,
	// configuration
	input wire logic i_quad_enable_bit,
	input wire logic i_four_wire_command_mode,
	input wire logic i_mode3,
	// request
	input wire logic i_start,
	input wire logic [7:0] i_opcode,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [LEN_W-1:0] i_nbytes,
	input wire logic [7:0] i_wdata,
	output logic o_wtake,
	// answer
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_busy,
	output logic o_done,
	// pin controls
	input wire logic i_pause,
	input wire logic i_hw_reset
);
	host_state_t state_r;
	logic [3:0] io_s1_r;
	logic [3:0] io_s2_r;
	logic [7:0] half_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [LEN_W:0] byte_idx_r;
	logic [7:0] op_r;
	logic [ADDR_W-1:0] addr_r;
	logic [LEN_W:0] total_r;
	logic [7:0] sr_r;
	logic [7:0] rsr_r;
	logic sck_r;
	logic cs_n_r;
	logic rst_oe_r;
	logic [3:0] io_o_r;
	logic [3:0] io_oe_r;
	logic pause_r;

	wire half_done = (half_cnt_r == 8'(SCK_HALF_CYC - 1));
	wire [3:0] step = i_four_wire_command_mode ? STEP_QUAD : STEP_SINGLE;
	wire [3:0] bit_sum = bit_cnt_r + step;
	wire byte_end = bit_sum[3];
	wire [7:0] rx_in = i_four_wire_command_mode ? {rsr_r[3:0], io_s2_r} : {rsr_r[6:0], io_s2_r[IO_SO]};
	wire [LEN_W:0] idx_nxt = byte_idx_r + 1'b1;
	wire in_data = (byte_idx_r >= (LEN_W+1)'(HDR_BYTES));
	wire next_data = (idx_nxt >= (LEN_W+1)'(HDR_BYTES));
	wire reading = op_r[DIR_BIT];
	wire last_byte = (idx_nxt == total_r);
	wire [7:0] next_byte = (idx_nxt == 1) ? addr_r[23:16] : (idx_nxt == 2) ? addr_r[15:8] :
		(idx_nxt == 3) ? addr_r[7:0] : (reading ? IDLE_TX_BYTE : i_wdata);
	wire can_pause = ~i_quad_enable_bit;
	wire drv_quad = ~(in_data & reading);
	// side pins keep their plain meaning only while quad enable is clear
	wire [1:0] side_o = {~pause_r, 1'b1};
	wire [1:0] side_oe = can_pause ? 2'b11 : 2'b00;

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			io_s1_r <= 4'hF;
			io_s2_r <= 4'hF;
			rst_oe_r <= 1'b0;
		end
		else
		begin
			io_s1_r <= link.io;
			io_s2_r <= io_s1_r;
			rst_oe_r <= i_hw_reset;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_r <= H_IDLE;
			half_cnt_r <= 8'h00;
			bit_cnt_r <= 4'h0;
			byte_idx_r <= '0;
			op_r <= 8'h00;
			addr_r <= '0;
			total_r <= '0;
			sr_r <= 8'h00;
			rsr_r <= 8'h00;
			sck_r <= 1'b0;
			cs_n_r <= 1'b1;
			io_o_r <= 4'h0;
			io_oe_r <= 4'h0;
			pause_r <= 1'b0;
			o_wtake <= 1'b0;
			o_rdata <= 8'h00;
			o_rvalid <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_wtake <= 1'b0;
			o_rvalid <= 1'b0;
			o_done <= 1'b0;
			half_cnt_r <= half_done ? 8'h00 : half_cnt_r + 8'h01;
			case (state_r)
				H_IDLE:
				begin
					sck_r <= i_mode3;
					cs_n_r <= 1'b1;
					io_oe_r <= {side_oe, 2'b00};
					io_o_r <= {side_o, 2'b00};
					half_cnt_r <= 8'h00;
					if (i_start & ~i_hw_reset)
					begin
						op_r <= i_opcode;
						addr_r <= i_addr;
						total_r <= (LEN_W+1)'(HDR_BYTES) + i_nbytes;
						sr_r <= i_opcode;
						byte_idx_r <= '0;
						bit_cnt_r <= 4'h0;
						cs_n_r <= 1'b0;
						o_busy <= 1'b1;
						state_r <= H_LEAD;
					end
				end
				H_LEAD:
					if (half_done)
						state_r <= H_LOW;
				H_LOW:
				begin
					sck_r <= 1'b0;
					if (i_four_wire_command_mode)
					begin
						io_o_r <= sr_r[7:4];
						io_oe_r <= drv_quad ? 4'hF : 4'h0;
					end
					else
					begin
						io_o_r <= {side_o, 1'b0, sr_r[7]};
						io_oe_r <= {side_oe, 2'b01};
					end
					if (half_done)
						state_r <= H_HIGH;
				end
				H_HIGH:
				begin
					sck_r <= 1'b1;
					if (half_done)
					begin
						rsr_r <= rx_in;
						bit_cnt_r <= byte_end ? 4'h0 : bit_sum;
						sr_r <= i_four_wire_command_mode ? {sr_r[3:0], 4'h0} : {sr_r[6:0], 1'b0};
						if (byte_end)
						begin
							byte_idx_r <= idx_nxt;
							sr_r <= next_byte;
							o_wtake <= next_data & ~reading & ~last_byte;
							o_rdata <= rx_in;
							o_rvalid <= in_data & reading;
						end
						if (byte_end & last_byte)
							state_r <= H_TRAIL;
						else if (i_pause & can_pause & ~i_four_wire_command_mode)
							state_r <= H_HOLD;
						else
							state_r <= H_LOW;
					end
				end
				H_HOLD:
				begin
					// sck stays high, so the pause pin never moves with a clock edge
					pause_r <= i_pause;
					io_o_r[IO_PAUSE] <= ~i_pause;
					if (i_pause)
						half_cnt_r <= 8'h00;
					else if (half_done)
						state_r <= H_LOW;
				end
				H_TRAIL:
				begin
					sck_r <= i_mode3;
					io_oe_r <= {side_oe, 2'b00};
					if (half_done)
					begin
						cs_n_r <= 1'b1;
						o_busy <= 1'b0;
						o_done <= 1'b1;
						state_r <= H_IDLE;
					end
				end
				default:
					state_r <= H_IDLE;
			endcase
			// the user must not raise reset while the device is busy storing
			if (i_hw_reset)
			begin
				cs_n_r <= 1'b1;
				o_busy <= 1'b0;
				state_r <= H_IDLE;
			end
		end
	end

	assign link.sck = sck_r;
	assign link.cs_n = cs_n_r;
	assign link.h_rst_n_o = 1'b0;
	assign link.h_rst_n_oe = rst_oe_r;
	assign link.h_io_o = io_o_r;
	assign link.h_io_oe = io_oe_r;

	if (LEN_W < 1 || SCK_HALF_CYC < 2 || SCK_HALF_CYC > 255)
	begin : g_param_check
		$error("unsupported host parameters");
	end
endmodule : flash_host_end

// ===== test/flash_link_checker.sv
// pin-level assertions on the link between the host end and the device end
// assumes it watches the shared bundle and the bench's quad and four-wire levels
`timescale 1ns/10ps
module flash_link_checker
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// link pins and configuration levels
	input wire logic sck,
	input wire logic cs_n,
	input wire rst_n,
	input wire [3:0] io,
	input wire logic [3:0] d_io_o,
	input wire logic [3:0] d_io_oe,
	input wire logic i_quad_enable_bit,
	input wire logic i_four_wire_command_mode
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	// oe may lag the pins by up to four cycles through the synchronisers
	desel_hiz_a: assert property (cs_n [*5] |-> d_io_oe == 4'h0)
		else $error("device drives a pin while deselected");
	pin_reset_hiz_a: assert property (!rst_n [*5] |-> d_io_oe == 4'h0)
		else $error("device drives a pin during pin reset");
	pause_hiz_a: assert property ((!i_quad_enable_bit && !cs_n && !io[3]) [*5] |-> !d_io_oe[1])
		else $error("data out driven while paused");
	quad_pins_a: assert property (!i_quad_enable_bit |-> d_io_oe[3:2] == 2'h0)
		else $error("upper data pins driven with quad off");
	single_in_a: assert property (!i_four_wire_command_mode |-> !d_io_oe[0])
		else $error("data in pin driven in single mode");
	out_edge_a: assert property ((sck && !cs_n && rst_n) [*4] |=> $stable(d_io_o))
		else $error("device data moved while clock high");
	idle_clk_a: assert property (cs_n [*8] |-> $stable(sck))
		else $error("serial clock moved while idle");
	half_len_a: assert property ($rose(sck) && !cs_n |=> sck [*3])
		else $error("serial clock high half too short");
	resume_a: assert property ($rose(io[3]) && !cs_n && !i_quad_enable_bit |-> ##[3:6] $fell(sck))
		else $error("clock did not resume after pause");

	cover property (!cs_n && d_io_oe[1]);
	cover property (!cs_n && d_io_oe == 4'hF);
	cover property (!cs_n && !io[3] && !i_quad_enable_bit);
	cover property (!rst_n);
endmodule : flash_link_checker

// ===== test/tb.sv
// self-checking bench: host end and device end joined by the link bundle
// assumes one 50 MHz reference and equal quad and four-wire levels at both ends
`timescale 1ns/10ps
module tb;
	import flash_pin_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst = 1'b1;
	logic qe = 1'b0, fw = 1'b0, mode3 = 1'b0, start = 1'b0, pause = 1'b0, hwrst = 1'b0;
	logic [7:0] opcode = 8'h00, wdata = 8'h00, nbytes = 8'h01, tx_data = 8'h00, rdata, rx_data;
	logic [ADDR_W-1:0] addr = 24'h000000, sector_base;
	logic tx_valid = 1'b0, rx_ready = 1'b0, wseen = 1'b0;
	logic wtake, rvalid, busy, done, tx_ready, rx_first, rx_valid, overrun;
	logic addr_valid, selected, paused, in_reset;
	logic [SECTOR_W-1:0] sector;
	logic [BLK32_W-1:0] blk32;
	logic [BLK64_W-1:0] blk64;
	int n_mismatch = 0, cmp_count = 0, wi = 0, ti = 0, rn = 0, av = 0;
	logic [8:0] rxq[$], expq[$];
	logic [7:0] wq[$], tq[$], rdq[$];
	flash_link_if link();

	always #10 i_ref_clk = ~i_ref_clk;

	flash_host_end flash_host_end_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link.host),
		.i_quad_enable_bit(qe), .i_four_wire_command_mode(fw), .i_mode3(mode3), .i_start(start),
		.i_opcode(opcode), .i_addr(addr), .i_nbytes(nbytes), .i_wdata(wdata), .o_wtake(wtake),
		.o_rdata(rdata), .o_rvalid(rvalid), .o_busy(busy), .o_done(done), .i_pause(pause),
		.i_hw_reset(hwrst));
	flash_dev_end flash_dev_end_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .link(link.dev),
		.i_quad_enable_bit(qe), .i_four_wire_command_mode(fw), .i_tx_data(tx_data),
		.i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_first(rx_first),
		.o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_overrun(overrun), .o_sector(sector),
		.o_blk32(blk32), .o_blk64(blk64), .o_sector_base(sector_base), .o_addr_valid(addr_valid),
		.o_selected(selected), .o_paused(paused), .o_in_reset(in_reset));
	flash_link_checker flash_link_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.sck(link.sck), .cs_n(link.cs_n), .rst_n(link.rst_n), .io(link.io), .d_io_o(link.d_io_o),
		.d_io_oe(link.d_io_oe), .i_quad_enable_bit(qe), .i_four_wire_command_mode(fw));

	always @(posedge i_ref_clk)
	begin
		if (rx_valid && rx_ready)
			rxq.push_back({rx_first, rx_data});
		if (rvalid)
			rdq.push_back(rdata);
		if (tx_valid && tx_ready)
			ti <= ti + 1;
		if (addr_valid)
			av <= av + 1;
	end

	// write data advances only once the take pulse has gone, so it stands across it
	always @(negedge i_ref_clk)
	begin
		rx_ready <= 1'($urandom_range(1));
		if (wseen && !wtake)
			wi = wi + 1;
		wseen = wtake;
		wdata <= (wi < wq.size()) ? wq[wi] : 8'h00;
		tx_valid <= (ti < rn);
		tx_data <= (ti < tq.size()) ? tq[ti] : 8'h00;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk

	task automatic give_verdict();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// one frame; give is how many bytes the device is offered for a read
	task automatic frame(input logic [7:0] op, input logic [23:0] a, input int n, input int give);
		int k;
		wq.delete();
		tq.delete();
		rxq.delete();
		rdq.delete();
		expq = '{{1'b1, op}, {1'b0, a[23:16]}, {1'b0, a[15:8]}, {1'b0, a[7:0]}};
		for (k = 0; k < n; k++)
		begin
			wq.push_back(8'($urandom));
			tq.push_back(8'($urandom));
			if (!op[DIR_BIT])
				expq.push_back({1'b0, wq[k]});
		end
		wi = 0;
		ti = 0;
		av = 0;
		rn = op[DIR_BIT] ? give : 0;
		@(negedge i_ref_clk);
		opcode <= op;
		addr <= a;
		nbytes <= 8'(n);
		start <= 1'b1;
		@(negedge i_ref_clk);
		start <= 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 3000)
		begin
			@(negedge i_ref_clk);
			k++;
		end
		chk("done", 1, {31'h0, done});
		repeat (16) @(negedge i_ref_clk);
		chk("rx count", expq.size(), rxq.size());
		for (k = 0; k < expq.size() && k < rxq.size(); k++)
			chk("rx byte", expq[k], rxq[k]);
		if (op[DIR_BIT])
		begin
			chk("read count", n, rdq.size());
			for (k = 0; k < n && k < rdq.size(); k++)
				chk("read byte", (k < give) ? tq[k] : IDLE_TX_BYTE, rdq[k]);
		end
		chk("sector", a[22:12], sector);
		chk("blk32", a[22:15], blk32);
		chk("blk64", a[22:16], blk64);
		chk("base", {1'b0, a[22:12], 12'h000}, sector_base);
		chk("overrun", 0, overrun);
		chk("addr valid", 1, av);
		chk("selected", 0, {31'h0, selected});
		chk("busy", 0, {31'h0, busy});
	endtask : frame

	initial
	begin : main
		logic [2:0] cfgs [5] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7};
		int c, j, n;
		void'($urandom(9998));
		for (c = 0; c < 5; c++)
		begin
			@(negedge i_ref_clk);
			i_rst <= 1'b1;
			{qe, fw, mode3} <= cfgs[c];
			repeat (4) @(negedge i_ref_clk);
			i_rst <= 1'b0;
			@(negedge i_ref_clk);
			frame(8'h02, 24'h000000, 1, 0);
			frame(8'h83, 24'hFFFFFF, 3, 2);
			for (j = 0; j < 4; j++)
			begin
				n = 1 + $urandom_range(3);
				frame({j[0], 7'($urandom)}, 24'($urandom), n, n - j[1]);
			end
			fork
				frame(8'h81, 24'($urandom), 4, 4);
				begin
					repeat (100) @(negedge i_ref_clk);
					pause <= 1'b1;
					repeat (35) @(negedge i_ref_clk);
					chk("paused", {31'h0, !qe}, {31'h0, paused});
					repeat (5) @(negedge i_ref_clk);
					pause <= 1'b0;
				end
			join
			// pin reset only while no frame runs
			hwrst <= 1'b1;
			repeat (10) @(negedge i_ref_clk);
			chk("in reset", 1, {31'h0, in_reset});
			chk("dev oe", 0, {28'h0, link.d_io_oe});
			hwrst <= 1'b0;
			repeat (10) @(negedge i_ref_clk);
			chk("float reset", 2'h1, {in_reset, link.rst_n});
		end
		give_verdict();
	end : main

	initial
	begin
		#1600000;
		n_mismatch++;
		give_verdict();
	end
endmodule : tb
